// File: common/seq_pkg.sv
// Shared constants, types and helpers for the engine start sequencer
package seq_pkg;
    localparam int CLK_HZ = 100_000_000;
    // Control sample period and delay tick
    localparam int SAMPLE_US = 1000;
    localparam int SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
    localparam int DLY_TICK_MS = 100;
    localparam int DLY_TICK_CYC = DLY_TICK_MS * (CLK_HZ / 1000);
    // Ramp denominators: position rate per second, setpoint rate per ten seconds, against clock cycles
    localparam int POS_DEN = CLK_HZ;
    localparam int SP_DEN = 10 * CLK_HZ;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_START = 8'h04;
    localparam logic [7:0] ADR_STOPRUN = 8'h08;
    localparam logic [7:0] ADR_HYST = 8'h0c;
    localparam logic [7:0] ADR_LIMITS = 8'h10;
    localparam logic [7:0] ADR_ACTRATE = 8'h14;
    localparam logic [7:0] ADR_DELAY = 8'h18;
    localparam logic [7:0] ADR_SETPTS = 8'h1c;
    localparam logic [7:0] ADR_SPRATE = 8'h20;
    localparam logic [7:0] ADR_RATIO = 8'h24;
    localparam logic [7:0] ADR_STATUS = 8'h28;
    localparam logic [7:0] ADR_SETPT = 8'h2c;
    // Field positions
    localparam int F_MODE = 0;
    localparam int F_TGT = 2;
    localparam int F_LO = 0;
    localparam int F_HI = 16;
    localparam int F_CFGOK = 5;
    // Fuel modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_RAMP = 2'h1;
    localparam logic [1:0] MODE_DELAY = 2'h2;
    // Reset values and legal ranges
    localparam logic [9:0] RATIO_RST = 10'h010;
    localparam logic [9:0] RATIO_MIN = 10'h001;
    localparam logic [9:0] RATIO_MAX = 10'h320;
    localparam logic [15:0] ARATE_RST = 16'h4e20;
    localparam logic [15:0] ARATE_MIN = 16'h0018;
    localparam logic [15:0] ARATE_MAX = 16'h4e20;
    localparam logic [12:0] SRATE_RST = 13'h0032;
    localparam logic [12:0] SRATE_MIN = 13'h0002;
    localparam logic [12:0] SRATE_MAX = 13'h1388;
    localparam logic [12:0] DLY_RST = 13'h000a;
    localparam logic [12:0] DLY_MIN = 13'h0001;
    localparam logic [12:0] DLY_MAX = 13'h10c2;
    localparam logic [13:0] POS_MAX = 14'h2710;

    typedef enum logic [4:0] {
        ST_STOPPED  = 5'h01,
        ST_FUEL1    = 5'h02,
        ST_FUEL2    = 5'h04,
        ST_RUN      = 5'h08,
        ST_STOPPING = 5'h10
    } seq_state_t;

    function automatic logic [15:0] steps_to_rpm(input logic [8:0] s);
        steps_to_rpm = {4'h0, s, 3'h0};
    endfunction : steps_to_rpm

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            be_merge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    endfunction : be_merge

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16
endpackage : seq_pkg

// File: logic/rate_ramp.sv
// Rate-limited value ramp, one step per accumulated rate quantum
`timescale 1ns/1ps
module rate_ramp #(
    parameter int W = 16,
    parameter int RW = 16,
    parameter int DEN = 1000
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Control
    input  wire logic          load_i,
    input  wire logic [W-1:0]  load_val_i,
    input  wire logic          run_i,
    input  wire logic [W-1:0]  target_i,
    input  wire logic [RW-1:0] rate_i,
    // Result
    output logic      [W-1:0]  value_o
);
    logic [31:0] acc_r;
    logic [31:0] sum;

    assign sum = acc_r + 32'(rate_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || load_i)
        begin
            acc_r   <= 32'h0;
            value_o <= rst_i ? '0 : load_val_i;
        end
        else if (run_i && value_o != target_i)
        begin
            // Rate never exceeds one unit per cycle, so one step suffices
            if (sum >= 32'(DEN))
            begin
                acc_r   <= sum - 32'(DEN);
                value_o <= (value_o < target_i) ? value_o + 1'b1 : value_o - 1'b1;
            end
            else
                acc_r <= sum;
        end
        else
            acc_r <= 32'h0;
    end
endmodule : rate_ramp

// File: logic/speed_scaler.sv
// Shaft to engine speed conversion by restoring division
`timescale 1ns/1ps
module speed_scaler (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Request
    input  wire logic        go_i,
    input  wire logic [15:0] shaft_i,
    input  wire logic [9:0]  ratio_i,
    // Result
    output logic      [15:0] engine_o,
    output logic             done_o
);
    logic [19:0] quo_r;
    logic [10:0] rem_r;
    logic [9:0]  div_r;
    logic [4:0]  cnt_r;
    logic        busy_r;
    logic [10:0] trial;

    assign trial = {rem_r[9:0], quo_r[19]};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_r   <= 1'b0;
            done_o   <= 1'b0;
            cnt_r    <= 5'h0;
            quo_r    <= 20'h0;
            rem_r    <= 11'h0;
            div_r    <= 10'h0;
            engine_o <= 16'h0;
        end
        else if (go_i && !busy_r)
        begin
            // Ratio is Q4, so the dividend carries four extra bits
            busy_r <= 1'b1;
            done_o <= 1'b0;
            cnt_r  <= 5'h14;
            quo_r  <= {shaft_i, 4'h0};
            rem_r  <= 11'h0;
            div_r  <= ratio_i;
        end
        else if (busy_r)
        begin
            rem_r <= (trial >= {1'b0, div_r}) ? trial - {1'b0, div_r} : trial;
            quo_r <= {quo_r[18:0], trial >= {1'b0, div_r}};
            cnt_r <= cnt_r - 5'h1;
            if (cnt_r == 5'h1)
                busy_r <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= cnt_r == 5'h0 && quo_r != 20'h0 ? 1'b0 : 1'b0;
            if (cnt_r == 5'h0 && div_r != 10'h0)
            begin
                engine_o <= (quo_r[19:16] != 4'h0) ? 16'hffff : quo_r[15:0];
                done_o   <= 1'b1;
                div_r    <= 10'h0;
            end
        end
    end
endmodule : speed_scaler

// File: logic/start_sequencer.sv
// Engine start sequencer with Wishbone configuration registers
`timescale 1ns/1ps
module start_sequencer #(
    parameter int SAMPLE_CYCLES = seq_pkg::SAMPLE_CYC,
    parameter int DELAY_TICK_CYCLES = seq_pkg::DLY_TICK_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Engine side
    input  wire logic [15:0] shaft_speed_i,
    input  wire logic        run_enable_i,
    input  wire logic        error_i,
    // Speed controller
    input  wire logic [13:0] pid_demand_i,
    output logic             pid_enable_o,
    output logic             pid_load_o,
    output logic      [13:0] pid_preload_o,
    output logic      [15:0] setpoint_o,
    // Actuator and status
    output logic      [13:0] pos_demand_o,
    output logic      [4:0]  state_o
);
    seq_pkg::seq_state_t st_r;
    seq_pkg::seq_state_t st_nxt;

    // Configuration
    logic [1:0]  mode_r;
    logic        tgt_min_r;
    logic [8:0]  s1_r;
    logic [8:0]  s2_r;
    logic [8:0]  stop_r;
    logic [8:0]  run_r;
    logic [8:0]  hyst_r;
    logic [13:0] lim1_r;
    logic [13:0] lim2_r;
    logic [15:0] arate_r;
    logic [12:0] dly_r;
    logic [15:0] rated_r;
    logic [15:0] minsp_r;
    logic [12:0] srate_r;
    logic [9:0]  ratio_r;

    // Pin synchronisers
    logic [15:0] spd_s1;
    logic [15:0] spd_s2;
    logic        run_s1;
    logic        run_s2;
    logic        err_s1;
    logic        err_s2;

    always_ff @(posedge clk_i)
    begin
        spd_s1 <= shaft_speed_i;
        spd_s2 <= spd_s1;
        run_s1 <= run_enable_i;
        run_s2 <= run_s1;
        err_s1 <= error_i;
        err_s2 <= err_s1;
    end

    // Control sample tick
    logic [31:0] smp_cnt_r;
    logic        go_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || smp_cnt_r == 32'(SAMPLE_CYCLES - 1))
            smp_cnt_r <= 32'h0;
        else
            smp_cnt_r <= smp_cnt_r + 32'h1;
        go_r <= !rst_i && smp_cnt_r == 32'(SAMPLE_CYCLES - 1);
    end

    logic [15:0] eng_w;
    logic        eng_done;
    logic [15:0] eng_r;
    logic        eval_r;

    speed_scaler u_scaler (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .go_i     (go_r),
        .shaft_i  (spd_s2),
        .ratio_i  (ratio_r),
        .engine_o (eng_w),
        .done_o   (eng_done)
    );

    always_ff @(posedge clk_i)
    begin
        eval_r <= !rst_i && eng_done;
        if (rst_i)
            eng_r <= 16'h0;
        else if (eng_done)
            eng_r <= eng_w;
    end

    logic [15:0] t_s1;
    logic [15:0] t_s2;
    logic [15:0] t_stop;
    logic [15:0] t_run;
    logic [8:0]  h_eff;
    logic [15:0] t_low;
    logic        cfg_ok;
    logic        dual;

    assign t_s1   = seq_pkg::steps_to_rpm(s1_r);
    assign t_s2   = seq_pkg::steps_to_rpm(s2_r);
    assign t_stop = seq_pkg::steps_to_rpm(stop_r);
    assign t_run  = seq_pkg::steps_to_rpm(run_r);
    assign dual   = mode_r != seq_pkg::MODE_SINGLE;
    // hysteresis held between half and all of first_start_fuel_state
    assign h_eff  = (hyst_r > s1_r) ? s1_r : ((hyst_r < (s1_r >> 1)) ? (s1_r >> 1) : hyst_r);
    assign t_low  = t_s1 - seq_pkg::steps_to_rpm(h_eff);
    // ordering; a bad set blocks starting
    assign cfg_ok = (s1_r < stop_r) && (stop_r < run_r) && (t_run < minsp_r)
                    && (!dual || (s1_r < s2_r && s2_r < stop_r));

    // Shutdown latch
    logic shut_r;

    always_ff @(posedge clk_i)
    begin
        // Set wins over the clear, so an error seen in stopped is kept
        if (rst_i)
            shut_r <= 1'b0;
        else if (err_s2)
            shut_r <= 1'b1;
        else if (st_r == seq_pkg::ST_STOPPED)
            shut_r <= 1'b0;
    end

    // Delay timer for the two-level delay mode
    logic [31:0] dtick_r;
    logic [12:0] dcnt_r;
    logic        dly_done;

    assign dly_done = (mode_r != seq_pkg::MODE_DELAY) || (dcnt_r >= dly_r);

    // hold time counted in second start fuel
    always_ff @(posedge clk_i)
    begin
        if (rst_i || st_r != seq_pkg::ST_FUEL2)
        begin
            dtick_r <= 32'h0;
            dcnt_r  <= 13'h0;
        end
        else if (!dly_done)
        begin
            if (dtick_r == 32'(DELAY_TICK_CYCLES - 1))
            begin
                dtick_r <= 32'h0;
                dcnt_r  <= dcnt_r + 13'h1;
            end
            else
                dtick_r <= dtick_r + 32'h1;
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        if (err_s2)
            st_nxt = seq_pkg::ST_STOPPING;
        else
        begin
            case (st_r)
                seq_pkg::ST_STOPPED:
                    if (eval_r && run_s2 && cfg_ok && eng_r > t_s1)
                        st_nxt = seq_pkg::ST_FUEL1;
                seq_pkg::ST_FUEL1, seq_pkg::ST_FUEL2:
                    if (!run_s2)
                        st_nxt = seq_pkg::ST_STOPPING;
                    else if (eval_r)
                    begin
                        if (eng_r < t_low)
                            st_nxt = seq_pkg::ST_STOPPING;
                        else if (eng_r > t_run)
                            st_nxt = seq_pkg::ST_RUN;
                        else if (st_r == seq_pkg::ST_FUEL1 && dual && eng_r > t_s2)
                            st_nxt = seq_pkg::ST_FUEL2;
                    end
                seq_pkg::ST_RUN:
                    if (!run_s2)
                        st_nxt = seq_pkg::ST_STOPPING;
                seq_pkg::ST_STOPPING:
                    if (eval_r)
                    begin
                        if (eng_r < t_stop)
                            st_nxt = seq_pkg::ST_STOPPED;
                        else if (!shut_r && run_s2 && eng_r > t_stop)
                            st_nxt = seq_pkg::ST_RUN;
                    end
                default:
                    st_nxt = seq_pkg::ST_STOPPING;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_r <= seq_pkg::ST_STOPPED;
        else
            st_r <= st_nxt;
    end

    logic        enter_f1;
    logic        enter_run;
    logic [13:0] pos_w;
    logic [15:0] sp_w;

    assign enter_f1  = st_r == seq_pkg::ST_STOPPED && st_nxt == seq_pkg::ST_FUEL1;
    assign enter_run = st_r != seq_pkg::ST_RUN && st_nxt == seq_pkg::ST_RUN;

    rate_ramp #(.W(14), .RW(16), .DEN(seq_pkg::POS_DEN)) u_pos_ramp (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (enter_f1),
        .load_val_i (lim1_r),
        .run_i      (st_r == seq_pkg::ST_FUEL2 && dly_done),
        .target_i   (lim2_r),
        .rate_i     (arate_r),
        .value_o    (pos_w)
    );

    rate_ramp #(.W(16), .RW(13), .DEN(seq_pkg::SP_DEN)) u_sp_ramp (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (enter_run),
        .load_val_i (t_run),
        .run_i      (st_r == seq_pkg::ST_RUN),
        .target_i   (tgt_min_r ? minsp_r : rated_r),
        .rate_i     (srate_r),
        .value_o    (sp_w)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pos_demand_o  <= 14'h0;
            pid_enable_o  <= 1'b0;
            pid_load_o    <= 1'b0;
            pid_preload_o <= 14'h0;
            setpoint_o    <= 16'h0;
            state_o       <= seq_pkg::ST_STOPPED;
        end
        else
        begin
            state_o    <= st_r;
            setpoint_o <= sp_w;
            // controller seeded with the open-loop demand
            pid_load_o <= enter_run;
            if (enter_run)
                pid_preload_o <= pos_demand_o;
            pid_enable_o <= st_r == seq_pkg::ST_RUN;
            case (st_r)
                // first level capped at its limit
                seq_pkg::ST_FUEL1:
                    pos_demand_o <= (pos_w > lim1_r) ? lim1_r : pos_w;
                seq_pkg::ST_FUEL2:
                    pos_demand_o <= pos_w;
                seq_pkg::ST_RUN:
                    // Hold while the controller takes its preload
                    pos_demand_o <= pid_load_o ? pos_demand_o : pid_demand_i;
                default:
                    pos_demand_o <= 14'h0;
            endcase
        end
    end

    // Register read view
    logic [31:0] rd;
    logic [31:0] wv;
    logic        acc;

    always_comb
    begin
        case (wb_adr_i)
            seq_pkg::ADR_CTRL:    rd = {29'h0, tgt_min_r, mode_r};
            seq_pkg::ADR_START:   rd = {7'h0, s2_r, 7'h0, s1_r};
            seq_pkg::ADR_STOPRUN: rd = {7'h0, run_r, 7'h0, stop_r};
            seq_pkg::ADR_HYST:    rd = {23'h0, hyst_r};
            seq_pkg::ADR_LIMITS:  rd = {2'h0, lim2_r, 2'h0, lim1_r};
            seq_pkg::ADR_ACTRATE: rd = {16'h0, arate_r};
            seq_pkg::ADR_DELAY:   rd = {19'h0, dly_r};
            seq_pkg::ADR_SETPTS:  rd = {minsp_r, rated_r};
            seq_pkg::ADR_SPRATE:  rd = {19'h0, srate_r};
            seq_pkg::ADR_RATIO:   rd = {22'h0, ratio_r};
            seq_pkg::ADR_STATUS:  rd = {eng_r, 10'h0, cfg_ok, st_r};
            seq_pkg::ADR_SETPT:   rd = {16'h0, sp_w};
            default:              rd = 32'h0;
        endcase
    end

    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wv  = seq_pkg::be_merge(rd, wb_dat_i, wb_sel_i);

    // Ack one cycle after the strobe; unmapped reads zero, writes dropped
    always_ff @(posedge clk_i)
    begin
        wb_ack_o <= !rst_i && acc;
        wb_dat_o <= rst_i ? 32'h0 : rd;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r    <= seq_pkg::MODE_SINGLE;
            tgt_min_r <= 1'b0;
            s1_r      <= 9'h0;
            s2_r      <= 9'h0;
            stop_r    <= 9'h0;
            run_r     <= 9'h0;
            hyst_r    <= 9'h0;
            lim1_r    <= 14'h0;
            lim2_r    <= 14'h0;
            arate_r   <= seq_pkg::ARATE_RST;
            dly_r     <= seq_pkg::DLY_RST;
            rated_r   <= 16'h0;
            minsp_r   <= 16'h0;
            srate_r   <= seq_pkg::SRATE_RST;
            ratio_r   <= seq_pkg::RATIO_RST;
        end
        else if (acc && wb_we_i)
        begin
            case (wb_adr_i)
                seq_pkg::ADR_CTRL:
                begin
                    mode_r    <= (wv[1:0] == 2'h3) ? seq_pkg::MODE_SINGLE : wv[1:0];
                    tgt_min_r <= wv[seq_pkg::F_TGT];
                end
                seq_pkg::ADR_START:
                begin
                    s1_r <= wv[seq_pkg::F_LO +: 9];
                    s2_r <= wv[seq_pkg::F_HI +: 9];
                end
                seq_pkg::ADR_STOPRUN:
                begin
                    stop_r <= wv[seq_pkg::F_LO +: 9];
                    run_r  <= wv[seq_pkg::F_HI +: 9];
                end
                seq_pkg::ADR_HYST:
                    hyst_r <= wv[8:0];
                seq_pkg::ADR_LIMITS:
                begin
                    lim1_r <= 14'(seq_pkg::clamp16({2'h0, wv[13:0]}, 16'h0, {2'h0, seq_pkg::POS_MAX}));
                    lim2_r <= 14'(seq_pkg::clamp16({2'h0, wv[29:16]}, 16'h0, {2'h0, seq_pkg::POS_MAX}));
                end
                seq_pkg::ADR_ACTRATE:
                    arate_r <= seq_pkg::clamp16(wv[15:0], seq_pkg::ARATE_MIN, seq_pkg::ARATE_MAX);
                seq_pkg::ADR_DELAY:
                    dly_r <= 13'(seq_pkg::clamp16({3'h0, wv[12:0]}, {3'h0, seq_pkg::DLY_MIN},
                                                  {3'h0, seq_pkg::DLY_MAX}));
                seq_pkg::ADR_SETPTS:
                begin
                    rated_r <= wv[15:0];
                    minsp_r <= wv[31:16];
                end
                seq_pkg::ADR_SPRATE:
                    srate_r <= 13'(seq_pkg::clamp16({3'h0, wv[12:0]}, {3'h0, seq_pkg::SRATE_MIN},
                                                    {3'h0, seq_pkg::SRATE_MAX}));
                seq_pkg::ADR_RATIO:
                    ratio_r <= 10'(seq_pkg::clamp16({6'h0, wv[9:0]}, {6'h0, seq_pkg::RATIO_MIN},
                                                    {6'h0, seq_pkg::RATIO_MAX}));
                default:
                    ;
            endcase
        end
    end
endmodule : start_sequencer

// File: verif/engine_model.sv
// Engine, run switch and speed controller model
`timescale 1ns/1ps
module engine_model (
    // Commands
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] spd_i,
    input  wire logic        run_i,
    input  wire logic        load_i,
    input  wire logic [13:0] pre_i,
    // Toward the sequencer
    output logic      [15:0] shaft_o,
    output logic             run_o,
    output logic      [13:0] pid_o
);
    always_ff @(posedge clk_i)
        {shaft_o, run_o} <= {spd_i, run_i};
    always_ff @(posedge clk_i)
        pid_o <= rst_i ? 14'h0 : (load_i ? pre_i : pid_o);
endmodule : engine_model

// File: verif/start_sequencer_chk.sv
// Port assertions for the start sequencer
`timescale 1ns/1ps
module start_sequencer_chk (
    // Clock and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Engine side
    input wire logic        error_i,
    input wire logic        pid_enable_o,
    input wire logic [13:0] pos_demand_o,
    input wire logic [4:0]  state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
    a_state_hot: assert property ($onehot(state_o)) else $error("state not one-hot");
    a_error_stop: assert property ($rose(error_i) |-> ##[1:6] state_o == 5'h10)
        else $error("error did not stop");
    a_shut_hold: assert property (state_o == 5'h10 && $past(error_i, 4) |=> state_o inside {5'h10, 5'h01})
        else $error("left stopping early");
    a_stop_exit: assert property (state_o == 5'h01 |=> state_o inside {5'h01, 5'h02, 5'h10})
        else $error("bad exit from stopped");
    a_fuel_open: assert property (state_o inside {5'h02, 5'h04} |-> ##1 !pid_enable_o || state_o == 5'h08)
        else $error("closed loop in start fuel");
    a_pid_run: assert property (pid_enable_o |-> ##[0:1] state_o == 5'h08) else $error("control off running");
    a_pos_cap: assert property (pos_demand_o <= 14'h2710) else $error("position over full travel");
    a_run_bumpless: assert property (state_o == 5'h08 && $past(state_o) != 5'h08
        |-> pos_demand_o == $past(pos_demand_o)) else $error("demand jumped at handover");
endmodule : start_sequencer_chk
bind start_sequencer start_sequencer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .error_i(error_i), .pid_enable_o(pid_enable_o),
    .pos_demand_o(pos_demand_o), .state_o(state_o));

// File: verif/start_sequencer_test.sv
// Bench for the start sequencer
`timescale 1ns/1ps
module start_sequencer_test;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, err = 1'b0;
    logic        ack, en, ld, run_en;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, q;
    logic [15:0] spd = 16'h0, shaft, spt;
    logic [13:0] pos, pd, pre;
    logic [4:0]  st;
    int          err_total = 0, compares = 0, n_clk = 0;
    start_sequencer #(.SAMPLE_CYCLES(64), .DELAY_TICK_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rd), .wb_ack_o(ack), .shaft_speed_i(shaft), .run_enable_i(run_en), .error_i(err),
        .pid_demand_i(pd), .pid_enable_o(en), .pid_load_o(ld), .pid_preload_o(pre), .setpoint_o(spt),
        .pos_demand_o(pos), .state_o(st));
    engine_model u_eng (.clk_i(clk_i), .rst_i(rst_i), .spd_i(spd), .run_i(run), .load_i(ld), .pre_i(pre),
        .shaft_o(shaft), .run_o(run_en), .pid_o(pd));
    initial
        forever #5 clk_i = ~clk_i;
    // Hang bound, far above the cycles needed
    always @(posedge clk_i)
    begin
        n_clk++;
        if (n_clk == 30000)
        begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rd;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic go(input logic [15:0] s, input logic r, input logic e, input logic [4:0] w);
        {spd, run, err} <= {s, r, e};
        for (int i = 0; i < 3000 && st !== w; i++)
            @(posedge clk_i);
        chk("state", {27'h0, w}, {27'h0, st});
    endtask : go
    task automatic t_regs;
        bus(1'b0, 8'h24, 32'h0);
        chk("ratio", 32'h10, q);
        bus(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 8'h04, 32'h000c_0008);
        bus(1'b1, 8'h08, 32'h0028_0014);
        bus(1'b1, 8'h0c, 32'h2);
        bus(1'b1, 8'h10, 32'h0bb8_1388);
        bus(1'b1, 8'h1c, 32'h0258_04b0);
        bus(1'b0, 8'h28, 32'h0);
        chk("cfg_ok", 32'h1, {31'h0, q[5]});
        bus(1'b1, 8'h18, 32'h1fff);
        bus(1'b0, 8'h18, 32'h0);
        chk("delay max", 32'h10c2, q);
        bus(1'b1, 8'h18, 32'h000a);
        $display("registers done");
    endtask : t_regs
    task automatic t_single;
        bus(1'b1, 8'h00, 32'h0);
        go(16'h0046, 1'b1, 1'b0, 5'h02);
        go(16'h0028, 1'b1, 1'b0, 5'h02);
        repeat (200) @(posedge clk_i);
        chk("hyst", 32'h2, {27'h0, st});
        go(16'h0018, 1'b1, 1'b0, 5'h10);
        go(16'h0000, 1'b1, 1'b0, 5'h01);
        go(16'h0064, 1'b1, 1'b0, 5'h02);
        chk("fuel1", 32'h1388, {18'h0, pos});
        go(16'h0190, 1'b1, 1'b0, 5'h08);
        chk("preload", 32'h1388, {18'h0, pre});
        chk("bumpless", 32'h1388, {18'h0, pos});
        repeat (100) @(posedge clk_i);
        chk("closed loop", 32'h1388, {18'h0, pos});
        chk("setpoint", 32'h0140, {16'h0, spt});
        chk("pid on", 32'h1, {31'h0, en});
        go(16'h00c8, 1'b1, 1'b1, 5'h10);
        // Error gone, speed above stop, run on: restart still refused
        go(16'h00c8, 1'b1, 1'b0, 5'h10);
        repeat (200) @(posedge clk_i);
        chk("hold", 32'h10, {27'h0, st});
        go(16'h0000, 1'b1, 1'b0, 5'h01);
        $display("single fuel done");
    endtask : t_single
    task automatic t_dual(input logic [1:0] m);
        bus(1'b1, 8'h00, {29'h0, 1'b1, m});
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl", {29'h0, 1'b1, m}, q);
        go(16'h0050, 1'b1, 1'b0, 5'h02);
        go(16'h0078, 1'b1, 1'b0, 5'h04);
        chk("fuel2", 32'h1388, {18'h0, pos});
        // One step per 5000 cycles at full rate; delay mode starts 200 cycles late
        repeat (5100) @(posedge clk_i);
        chk("ramp", (m == 2'h1) ? 32'h1387 : 32'h1388, {18'h0, pos});
        go(16'h0190, 1'b1, 1'b0, 5'h08);
        go(16'h0190, 1'b0, 1'b0, 5'h10);
        go(16'h0190, 1'b1, 1'b0, 5'h08);
        // Slow down while running, so stopping sees a fresh low speed
        go(16'h0064, 1'b1, 1'b0, 5'h08);
        repeat (200) @(posedge clk_i);
        go(16'h0064, 1'b0, 1'b0, 5'h10);
        go(16'h0064, 1'b1, 1'b0, 5'h01);
        go(16'h0064, 1'b1, 1'b0, 5'h02);
        go(16'h0000, 1'b1, 1'b0, 5'h01);
        $display("dual fuel mode %0d done", m);
    endtask : t_dual
    task automatic complete_run;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset state", 32'h1, {27'h0, st});
        t_regs();
        t_single();
        t_dual(2'h1);
        t_dual(2'h2);
        complete_run();
    end
endmodule : start_sequencer_test
